// ===== logic/prm_routing.sv
`timescale 1ns/1ns
`include "prm_consts.svh"
// ==========================================
// Digital pin routing matrix
//
// Peripheral inputs each pick a source pin, pins each pick a peripheral
// output. Analog functions never enter here; they stay on their own pins.
// Every output below is registered, so routing and pin data show up one
// clock after the inputs that cause them.

// Notes on behaviour
// - Matrix routes digital signals only, never analog
// - Input and output routing configured independently
// - Each peripheral input has own select, shared encoding
// - Each pin has own output source select
// - Direction bit normally owns the output driver
// - Serial and I2C engines may override direction
// - Input codes: A0-5, B4-7 large, C0-7 large, C0-5 small
// - Dedicated I2C buffers only on RB1,RB2,RC3,RC4
// - I2C mode there ignores input level select
// - Lock flag freezes every routing selection
// - Lock changes only right after unlock sequence
// - Sequence: 0x55, 0xAA, then lock write
// - Fuse: one clear, one set per reset
// - Power-on reset restores defaults, drops lock
// - Selections kept unchanged through sleep
module prm_routing #(
  parameter int NUM_IN = `PRM_NUM_IN,
  parameter int NUM_PIN = `PRM_NUM_PIN,
  parameter bit LARGE = 1'b1
) (
  input wire logic CLK, // System clock, 25 MHz
  input wire logic RST_B, // Power-on reset, active low
  input wire logic IN_WR, // Input select write strobe
  input wire logic [$clog2(NUM_IN)-1:0] IN_WR_IDX, // Peripheral input written
  input wire logic [`PRM_IN_SEL_W-1:0] IN_WR_DATA, // Source pin code
  input wire logic [$clog2(NUM_IN)-1:0] IN_RD_IDX, // Input select read back
  output logic [`PRM_IN_SEL_W-1:0] IN_RD_DATA, // Input select readback
  input wire logic OUT_WR, // Output select write strobe
  input wire logic [$clog2(NUM_PIN)-1:0] OUT_WR_IDX, // Pin slot written
  input wire logic [`PRM_OUT_SEL_W-1:0] OUT_WR_DATA, // Output source code
  input wire logic [$clog2(NUM_PIN)-1:0] OUT_RD_IDX, // Output select read back
  output logic [`PRM_OUT_SEL_W-1:0] OUT_RD_DATA, // Output select readback
  input wire logic LOCK_WR, // Lock register write strobe
  input wire logic [7:0] LOCK_WR_DATA, // Lock register write data
  input wire logic ONE_TIME_LOCK_FUSE, // Fuse: lock once per reset
  output logic ROUTING_LOCK_FLAG, // Selections frozen
  input wire logic [NUM_PIN-1:0] PIN_DIRECTION_CONTROL, // 1 = input, driver off
  input wire logic [NUM_PIN-1:0] PORT_LATCH, // Port latch per pin
  input wire logic [NUM_PIN-1:0] INPUT_LEVEL_SELECT, // 1 = Schmitt, 0 = TTL
  input wire logic I2C_MODE, // Serial engine runs I2C
  input wire logic [NUM_PIN-1:0] PIN_TTL_IN, // Pin level via TTL buffer
  input wire logic [NUM_PIN-1:0] PIN_SCHMITT_IN, // Pin level via Schmitt buffer
  input wire logic [NUM_PIN-1:0] PIN_I2C_IN, // Pin level via I2C buffer
  output logic [NUM_PIN-1:0] PIN_OUT, // Pin output data
  output logic [NUM_PIN-1:0] PIN_OE, // Pin output enable, high drives
  output logic [NUM_PIN-1:0] PIN_I2C_THRESH, // I2C thresholds in force
  input wire logic [31:0] PERIPH_OUT, // Peripheral outputs by source code
  input wire logic [31:0] PERIPH_OE_OVR, // Source takes over the driver
  input wire logic [31:0] PERIPH_OE, // Driver enable while overriding
  output logic [NUM_IN-1:0] PERIPH_IN // Routed peripheral inputs
);
  localparam int IW = `PRM_IN_SEL_W;
  localparam int OW = `PRM_OUT_SEL_W;

  // Which pin slots exist on this variant
  localparam logic [NUM_PIN-1:0] PRESENT = LARGE ? `PRM_PINS_LARGE : `PRM_PINS_SMALL;
  localparam logic [NUM_PIN-1:0] I2C_BUF = `PRM_I2C_BUF_PINS;
  localparam logic [NUM_IN*IW-1:0] IN_DEF = LARGE ? `PRM_IN_DEF_LARGE : `PRM_IN_DEF_SMALL;
  localparam logic [NUM_PIN*OW-1:0] OUT_DEF = {NUM_PIN{`PRM_OUT_DEF}};

  // ==========================================
  // State
  typedef struct packed {
    logic [NUM_PIN-1:0] pin_out; // Registered pin data
    logic [NUM_PIN-1:0] pin_oe;  // Registered driver enables
    logic [NUM_PIN-1:0] i2c_thr; // Registered threshold selects
    logic [NUM_IN-1:0] periph_in; // Registered peripheral inputs
  } prm_route_s;

  prm_route_s st;
  prm_route_s next_st;

  logic locked;                     // Lock flag from the controller
  logic [NUM_IN*IW-1:0] in_sel;     // All input select codes
  logic [NUM_PIN*OW-1:0] out_sel;   // All output select codes
  logic [NUM_PIN-1:0] pin_lvl;      // Pin level after buffer choice

  // ==========================================
  // Lock controller
  // Both banks share its flag, so one unlock frees every selection
  prm_lock u_lock (
    .clk(CLK),
    .rst_b(RST_B),
    .wr_en(LOCK_WR),
    .wr_data(LOCK_WR_DATA),
    .fuse(ONE_TIME_LOCK_FUSE),
    .flag(locked)
  );

  // ==========================================
  // Select banks: two separate banks so that input and output
  // routing never share a write path or an encoding
  prm_sel_bank #(
    .N(NUM_IN),
    .W(IW),
    .RST_VAL(IN_DEF)
  ) u_in_bank (
    .clk(CLK),
    .rst_b(RST_B),
    .wr_en(IN_WR),
    .wr_idx(IN_WR_IDX),
    .wr_data(IN_WR_DATA),
    .locked(locked),
    .rd_idx(IN_RD_IDX),
    .rd_data(IN_RD_DATA),
    .vals(in_sel)
  );

  prm_sel_bank #(
    .N(NUM_PIN),
    .W(OW),
    .RST_VAL(OUT_DEF)
  ) u_out_bank (
    .clk(CLK),
    .rst_b(RST_B),
    .wr_en(OUT_WR),
    .wr_idx(OUT_WR_IDX),
    .wr_data(OUT_WR_DATA),
    .locked(locked),
    .rd_idx(OUT_RD_IDX),
    .rd_data(OUT_RD_DATA),
    .vals(out_sel)
  );

  // ==========================================
  // Input buffer choice per pin. Only four slots own an I2C buffer;
  // I2C mapped elsewhere is read through the plain level buffer,
  // which software is expected to avoid
  always_comb begin
    for (int p = 0; p < NUM_PIN; p++) begin
      if (I2C_MODE && I2C_BUF[p]) begin
        pin_lvl[p] = PIN_I2C_IN[p];
      end else begin
        pin_lvl[p] = INPUT_LEVEL_SELECT[p] ? PIN_SCHMITT_IN[p] : PIN_TTL_IN[p];
      end
    end
  end

  // ==========================================
  // Routing. Only digital levels pass; there is no analog path here
  always_comb begin
    logic [OW-1:0] src;
    logic [IW-1:0] code;
    logic ovr;
    src = '0;
    code = '0;
    ovr = 1'b0;
    next_st = st;
    // Output side: each pin takes its chosen source
    for (int p = 0; p < NUM_PIN; p++) begin
      src = out_sel[p*OW +: OW];
      // Code zero hands the pin back to the port latch
      // and never takes the driver, whatever bit zero of the override says
      ovr = (src != `PRM_SRC_LATCH) && PERIPH_OE_OVR[src];
      if (!PRESENT[p]) begin
        // Missing pins stay quiet whatever is written for them
        next_st.pin_out[p] = 1'b0;
        next_st.pin_oe[p] = 1'b0;
      end else begin
        next_st.pin_out[p] = (src == `PRM_SRC_LATCH) ? PORT_LATCH[p] : PERIPH_OUT[src];
        if (ovr) begin
          // Bidirectional engines steer the driver themselves; this
          // relies on input and output being mapped to the same pin
          next_st.pin_oe[p] = PERIPH_OE[src];
        end else begin
          next_st.pin_oe[p] = !PIN_DIRECTION_CONTROL[p];
        end
      end
      next_st.i2c_thr[p] = I2C_MODE && I2C_BUF[p] && PRESENT[p];
    end
    // Input side: each peripheral input takes its chosen pin
    for (int i = 0; i < NUM_IN; i++) begin
      code = in_sel[i*IW +: IW];
      // Codes in the gaps or past port C read as low
      // Bit 5 only counts through the range test; the slot index is five bits
      if (code < `PRM_CODE_LIMIT && PRESENT[code[4:0]]) begin
        next_st.periph_in[i] = pin_lvl[code[4:0]];
      end else begin
        next_st.periph_in[i] = 1'b0;
      end
    end
  end

  // ==========================================
  // State register; idle, drivers off, at power-on
  // A register on every path keeps the pins free of decode glitches,
  // at the cost of one clock between a select write and the pin
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Outputs, all from flip-flops
  // The lock flag comes straight from the controller's own register
  assign PIN_OUT = st.pin_out;
  assign PIN_OE = st.pin_oe;
  assign PIN_I2C_THRESH = st.i2c_thr;
  assign PERIPH_IN = st.periph_in;
  assign ROUTING_LOCK_FLAG = locked;

  // ==========================================
  // Checks
  logic [OW-1:0] chk_src0;  // Source chosen for slot 0
  logic chk_ovr0;           // Slot 0 driver taken over
  logic chk_oe0;            // Enable requested by that source
  logic [IW-1:0] chk_code0; // Pin chosen for input 0

  assign chk_src0 = out_sel[OW-1:0];
  assign chk_ovr0 = (chk_src0 != `PRM_SRC_LATCH) && PERIPH_OE_OVR[chk_src0];
  assign chk_oe0 = PERIPH_OE[chk_src0];
  assign chk_code0 = in_sel[IW-1:0];

  sequence s_no_override;
    PERIPH_OE_OVR == 32'h0000_0000;
  endsequence

  a_dir_owns: assert property (@(posedge CLK) disable iff (!RST_B)
    s_no_override |=> PIN_OE == (~$past(PIN_DIRECTION_CONTROL) & PRESENT))
    else $error("direction bit lost the driver");

  a_override_wins: assert property (@(posedge CLK) disable iff (!RST_B)
    (chk_ovr0 && PRESENT[0]) |=> PIN_OE[0] == $past(chk_oe0))
    else $error("override enable not applied");

  a_i2c_thresh: assert property (@(posedge CLK) disable iff (!RST_B)
    I2C_MODE |=> PIN_I2C_THRESH == (I2C_BUF & PRESENT))
    else $error("I2C thresholds wrong");

  a_gap_code_low: assert property (@(posedge CLK) disable iff (!RST_B)
    (chk_code0 >= `PRM_CODE_LIMIT || !PRESENT[chk_code0[4:0]]) |=> !PERIPH_IN[0])
    else $error("unmapped input code not low");

  a_absent_quiet: assert property (@(posedge CLK) disable iff (!RST_B)
    (PIN_OE & ~PRESENT) == '0)
    else $error("missing pin driven");

  // ==========================================
  // Further checks on the banks, the thresholds and absent pins, and on pin slot 0 and input 0. Slot 0 is present on
  // both variants, so these hold whichever table is built in
  logic chk_dat0;       // Data the chosen source offers slot 0
  logic [4:0] chk_pin0; // Pin slot named by input 0's code
  logic chk_lvl0;       // Level of that pin through its buffer

  assign chk_dat0 = (chk_src0 == `PRM_SRC_LATCH) ? PORT_LATCH[0] : PERIPH_OUT[chk_src0];
  assign chk_pin0 = chk_code0[4:0];
  // An out of range slot only feeds this when the code is refused
  assign chk_lvl0 = (I2C_MODE && I2C_BUF[chk_pin0]) ? PIN_I2C_IN[chk_pin0] :
    (INPUT_LEVEL_SELECT[chk_pin0] ? PIN_SCHMITT_IN[chk_pin0] : PIN_TTL_IN[chk_pin0]);

  sequence s_pin0_valid;
    chk_code0 < `PRM_CODE_LIMIT && PRESENT[chk_pin0];
  endsequence

  // Each bank moves only on its own strobe
  a_in_own_write: assert property (@(posedge CLK) disable iff (!RST_B)
    !IN_WR |=> $stable(in_sel))
    else $error("input selects moved without a write");

  a_out_own_write: assert property (@(posedge CLK) disable iff (!RST_B)
    !OUT_WR |=> $stable(out_sel))
    else $error("output selects moved without a write");

  a_lock_freezes: assert property (@(posedge CLK) disable iff (!RST_B)
    ROUTING_LOCK_FLAG |=> $stable(in_sel) && $stable(out_sel))
    else $error("selects moved while locked");

  // Slot 0 carries the latch or its peripheral one clock after the choice
  a_slot0_data: assert property (@(posedge CLK) disable iff (!RST_B)
    PRESENT[0] |=> PIN_OUT[0] == $past(chk_dat0))
    else $error("slot 0 data not from its source");

  // Input 0 reads its pin through the buffer that the mode and level
  // select pick; refused codes are covered by the gap check above
  a_input_follows: assert property (@(posedge CLK) disable iff (!RST_B)
    s_pin0_valid |=> PERIPH_IN[0] == $past(chk_lvl0))
    else $error("input 0 not from its pin");

  // Thresholds follow the mode and stay off pins without the buffer
  a_thresh_off: assert property (@(posedge CLK) disable iff (!RST_B)
    !I2C_MODE |=> PIN_I2C_THRESH == '0)
    else $error("I2C thresholds outside I2C mode");

  a_thresh_where: assert property (@(posedge CLK) disable iff (!RST_B)
    (PIN_I2C_THRESH & ~I2C_BUF) == '0)
    else $error("I2C thresholds on a plain pin");

  // Slots that the variant lacks never show data either
  a_absent_low: assert property (@(posedge CLK) disable iff (!RST_B)
    (PIN_OUT & ~PRESENT) == '0)
    else $error("missing pin shows data");
endmodule

// ===== common/prm_consts.svh
`ifndef PRM_CONSTS_SVH
`define PRM_CONSTS_SVH
// ==========================================
// Select code geometry
`define PRM_IN_SEL_W 6
`define PRM_OUT_SEL_W 5
`define PRM_NUM_IN 20
`define PRM_NUM_PIN 24
// First code past the last pin slot
`define PRM_CODE_LIMIT 6'h18
// Output code that hands the pin back to its port latch
`define PRM_SRC_LATCH 5'h00
// Pin codes: port A bits 0..5, port B bits 4..7, port C bits 0..7
`define PRM_CODE_RA0 6'h00
`define PRM_CODE_RB4 6'h0C
`define PRM_CODE_RC0 6'h10
// ==========================================
// Pin slot masks, one bit per code
`define PRM_PINS_LARGE 24'hFF_F03F
`define PRM_PINS_SMALL 24'h3F_003F
// Slots of RB1, RB2, RC3 and RC4 carry the dedicated I2C buffers
`define PRM_I2C_BUF_PINS 24'h18_0600
// ==========================================
// Lock register
`define PRM_UNLOCK_1 8'h55
`define PRM_UNLOCK_2 8'hAA
`define PRM_LOCK_BIT 0
// ==========================================
// Power-on input defaults, input 19 leftmost, input 0 rightmost
`define PRM_IN_DEF_LARGE {6'h10, 6'h11, 6'h0F, 6'h0D, 6'h16, 6'h0C, 6'h0E, 6'h12, 6'h0D, 6'h0C, \
  6'h13, 6'h02, 6'h02, 6'h13, 6'h15, 6'h05, 6'h04, 6'h05, 6'h02, 6'h02}
`define PRM_IN_DEF_SMALL {6'h10, 6'h11, 6'h14, 6'h15, 6'h13, 6'h11, 6'h10, 6'h12, 6'h05, 6'h11, \
  6'h14, 6'h13, 6'h02, 6'h13, 6'h15, 6'h05, 6'h04, 6'h05, 6'h02, 6'h02}
// Power-on output default: every pin driven by its latch
`define PRM_OUT_DEF 5'h00
`endif

// ===== common/prm_pkg.sv
package prm_pkg;
  // ==========================================
  // Unlock sequence progress
  typedef enum logic [1:0] {
    PRM_SEQ_IDLE,
    PRM_SEQ_GOT1,
    PRM_SEQ_ARMED
  } prm_seq_e;

  // State of the lock controller
  typedef struct packed {
    prm_seq_e seq;       // Progress through the unlock writes
    logic flag;          // Routing lock flag
    logic cleared_once;  // A clear was spent under the fuse
    logic perm;          // Set under the fuse, sticks until reset
  } prm_lock_s;
endpackage

// ===== logic/prm_sel_bank.sv
`timescale 1ns/1ns
`include "prm_consts.svh"
// Bank of select registers with one shared code encoding
module prm_sel_bank #(
  parameter int N = 20,
  parameter int W = 6,
  parameter logic [N*W-1:0] RST_VAL = '0
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Power-on reset, active low
  input wire logic wr_en, // Write strobe, one cycle
  input wire logic [$clog2(N)-1:0] wr_idx, // Register written
  input wire logic [W-1:0] wr_data, // New select code
  input wire logic locked, // Routing lock flag
  input wire logic [$clog2(N)-1:0] rd_idx, // Register read back
  output logic [W-1:0] rd_data, // Readback, registered
  output logic [N*W-1:0] vals // Every code, flat
);
  typedef struct packed {
    logic [N*W-1:0] vals; // Select codes
    logic [W-1:0] rd;     // Readback register
  } prm_bank_s;

  prm_bank_s st;
  prm_bank_s next_st;

  // ==========================================
  // Next state: a locked write is dropped silently
  always_comb begin
    next_st = st;
    if (wr_en && !locked && (int'(wr_idx) < N)) begin
      next_st.vals[int'(wr_idx)*W +: W] = wr_data;
    end
    next_st.rd = (int'(rd_idx) < N) ? st.vals[int'(rd_idx)*W +: W] : '0;
  end

  // Only power-on reset reloads the default codes; sleep has no path in here
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= {RST_VAL, {W{1'b0}}};
    end else begin
      st <= next_st;
    end
  end

  assign vals = st.vals;
  assign rd_data = st.rd;

  // ==========================================
  // Checks
  a_locked_hold: assert property (@(posedge clk) disable iff (!rst_b)
    locked |=> $stable(vals)) else $error("select changed while locked");
  a_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
    (wr_en && !locked && int'(wr_idx) < N) |=> vals[int'($past(wr_idx))*W +: W] == $past(wr_data))
    else $error("unlocked write did not land");
endmodule

// ===== logic/prm_lock.sv
`timescale 1ns/1ns
`include "prm_consts.svh"
// Lock flag behind the two-write unlock sequence
module prm_lock (
  input wire logic clk, // System clock
  input wire logic rst_b, // Power-on reset, active low
  input wire logic wr_en, // Lock register write, one cycle
  input wire logic [7:0] wr_data, // Lock register write data
  input wire logic fuse, // One-time lock fuse
  output logic flag // Routing lock flag
);
  prm_pkg::prm_lock_s st;
  prm_pkg::prm_lock_s next_st;
  logic want;

  // ==========================================
  // Sequence tracker; any stray write restarts it
  always_comb begin
    next_st = st;
    want = wr_data[`PRM_LOCK_BIT];
    if (wr_en) begin
      case (st.seq)
        prm_pkg::PRM_SEQ_IDLE: begin
          next_st.seq = (wr_data == `PRM_UNLOCK_1) ? prm_pkg::PRM_SEQ_GOT1 : prm_pkg::PRM_SEQ_IDLE;
        end
        prm_pkg::PRM_SEQ_GOT1: begin
          if (wr_data == `PRM_UNLOCK_2) begin
            next_st.seq = prm_pkg::PRM_SEQ_ARMED;
          end else if (wr_data == `PRM_UNLOCK_1) begin
            next_st.seq = prm_pkg::PRM_SEQ_GOT1;
          end else begin
            next_st.seq = prm_pkg::PRM_SEQ_IDLE;
          end
        end
        prm_pkg::PRM_SEQ_ARMED: begin
          next_st.seq = prm_pkg::PRM_SEQ_IDLE;
          // Under the fuse one clear and one set are allowed per reset
          if (want && !st.flag) begin
            next_st.flag = 1'b1;
            next_st.perm = fuse;
          end else if (!want && st.flag && !(fuse && (st.perm || st.cleared_once))) begin
            next_st.flag = 1'b0;
            next_st.cleared_once = fuse;
          end
        end
        default: begin
          next_st.seq = prm_pkg::PRM_SEQ_IDLE;
        end
      endcase
    end
  end

  // Power-on reset removes the permanent lock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st <= '{seq: prm_pkg::PRM_SEQ_IDLE, flag: 1'b0, cleared_once: 1'b0, perm: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign flag = st.flag;

  // ==========================================
  // Checks
  sequence s_unlock;
    (wr_en && wr_data == `PRM_UNLOCK_1) ##1 (wr_en && wr_data == `PRM_UNLOCK_2);
  endsequence

  a_unlock_takes: assert property (@(posedge clk) disable iff (!rst_b)
    s_unlock ##1 (wr_en && !fuse) |=> flag == $past(want)) else $error("unlocked write not taken");
  a_flag_guarded: assert property (@(posedge clk) disable iff (!rst_b)
    $changed(flag) |-> $past(wr_en) && $past(st.seq) == prm_pkg::PRM_SEQ_ARMED)
    else $error("flag moved off sequence");
  a_perm_holds: assert property (@(posedge clk) disable iff (!rst_b)
    (fuse && st.perm && flag) |=> flag) else $error("permanent lock released");
endmodule

// ===== test/prm_far_side.sv
`timescale 1ns/1ns
// ==========================================
// Far side: pad levels as each input buffer sees them
module prm_far_side (
  input wire logic [23:0] pat, // Pad levels
  output logic [23:0] ttl, // TTL buffer view
  output logic [23:0] smt, // Schmitt buffer view
  output logic [23:0] i2c // I2C buffer view
);
  // Schmitt differs from TTL on even slots only; the I2C view differs from TTL on every slot
  assign ttl = pat;
  assign smt = pat ^ 24'h55_5555;
  // Dedicated buffers invert on every slot, the Schmitt view on even slots only
  assign i2c = ~pat;
endmodule

// ===== test/testbench.sv
`timescale 1ns/1ns
// ==========================================
// Self-checking bench for the routing matrix
module testbench;
  logic clk = 1'b0; // System clock
  logic rst_b = 1'b0; // Power-on reset
  logic in_wr = 1'b0; // Input select strobe
  logic [4:0] in_wr_idx = 5'h00;
  logic [5:0] in_wr_data = 6'h00;
  logic [4:0] in_rd_idx = 5'h00;
  logic [5:0] in_rd_data;
  logic out_wr = 1'b0; // Output select strobe
  logic [4:0] out_wr_idx = 5'h00;
  logic [4:0] out_wr_data = 5'h00;
  logic [4:0] out_rd_idx = 5'h00;
  logic [4:0] out_rd_data;
  logic lock_wr = 1'b0; // Lock register strobe
  logic [7:0] lock_wr_data = 8'h00;
  logic fuse = 1'b0; // One-time lock fuse
  logic flag;
  logic [23:0] dir = 24'hFF_FFFF; // Direction, all inputs
  logic [23:0] latch = 24'h5A_5A5A; // Port latches
  logic [23:0] lvl = 24'h00_0000; // Input level select
  logic i2c_mode = 1'b0;
  logic [23:0] pat = 24'hA5_3C96; // Pad levels
  logic [23:0] ttl, smt, i2c;
  logic [23:0] pin_out, pin_oe, pin_thr;
  logic [31:0] p_out = 32'hC3A5_5A3C; // Peripheral outputs
  logic [31:0] p_ovr = 32'h0000_0000;
  logic [31:0] p_oe = 32'h0000_0000;
  logic [19:0] p_in;
  int errors = 0;
  int tests_run = 0;
  // Power-on source pins, input 0 first
  localparam logic [5:0] IN_DEF [20] = '{6'h02, 6'h02, 6'h05, 6'h04, 6'h05, 6'h15, 6'h13, 6'h02, 6'h02, 6'h13,
    6'h0C, 6'h0D, 6'h12, 6'h0E, 6'h0C, 6'h16, 6'h0D, 6'h0F, 6'h11, 6'h10};
  // Pin slots that exist on the larger variant
  localparam logic [23:0] PINS = 24'hFF_F03F;

  prm_routing u_prm_routing (.CLK(clk), .RST_B(rst_b), .IN_WR(in_wr), .IN_WR_IDX(in_wr_idx),
    .IN_WR_DATA(in_wr_data), .IN_RD_IDX(in_rd_idx), .IN_RD_DATA(in_rd_data), .OUT_WR(out_wr),
    .OUT_WR_IDX(out_wr_idx), .OUT_WR_DATA(out_wr_data), .OUT_RD_IDX(out_rd_idx), .OUT_RD_DATA(out_rd_data),
    .LOCK_WR(lock_wr), .LOCK_WR_DATA(lock_wr_data), .ONE_TIME_LOCK_FUSE(fuse), .ROUTING_LOCK_FLAG(flag),
    .PIN_DIRECTION_CONTROL(dir), .PORT_LATCH(latch), .INPUT_LEVEL_SELECT(lvl), .I2C_MODE(i2c_mode),
    .PIN_TTL_IN(ttl), .PIN_SCHMITT_IN(smt), .PIN_I2C_IN(i2c), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PIN_I2C_THRESH(pin_thr), .PERIPH_OUT(p_out), .PERIPH_OE_OVR(p_ovr), .PERIPH_OE(p_oe), .PERIPH_IN(p_in));
  prm_far_side u_prm_far_side (.pat(pat), .ttl(ttl), .smt(smt), .i2c(i2c));

  // Clock, 40 ns period
  always #20 clk = ~clk;

  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Strobes drop a cycle later, so back-to-back calls never collide
  task automatic wr_in(input logic [4:0] idx, input logic [5:0] code);
    @(negedge clk);
    in_wr = 1'b1;
    in_wr_idx = idx;
    in_wr_data = code;
    @(negedge clk);
    in_wr = 1'b0;
  endtask
  task automatic wr_out(input logic [4:0] idx, input logic [4:0] code);
    @(negedge clk);
    out_wr = 1'b1;
    out_wr_idx = idx;
    out_wr_data = code;
    @(negedge clk);
    out_wr = 1'b0;
  endtask
  task automatic wr_lock(input logic [7:0] d);
    @(negedge clk);
    lock_wr = 1'b1;
    lock_wr_data = d;
    @(negedge clk);
    lock_wr = 1'b0;
  endtask
  // Full unlock sequence and flag write on three back-to-back edges
  task automatic lock_seq(input logic [7:0] d);
    @(negedge clk);
    lock_wr = 1'b1;
    lock_wr_data = 8'h55;
    @(negedge clk);
    lock_wr_data = 8'hAA;
    @(negedge clk);
    lock_wr_data = d;
    @(negedge clk);
    lock_wr = 1'b0;
  endtask
  task automatic power_on;
    rst_b = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
  endtask
  // Level a peripheral input should see for a given source code
  function automatic logic exp_in(input logic [5:0] code);
    logic [4:0] p;
    p = code[4:0];
    if (code >= 6'h18 || !PINS[p]) return 1'b0;
    if (i2c_mode && (p == 9 || p == 10 || p == 19 || p == 20)) return i2c[p];
    return lvl[p] ? smt[p] : ttl[p];
  endfunction

  // ==========================================
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 20; i++) begin
      in_rd_idx = i[4:0];
      @(negedge clk);
      chk(in_rd_data, IN_DEF[i], "input default");
    end
    for (int i = 0; i < 24; i++) begin
      out_rd_idx = i[4:0];
      @(negedge clk);
      if (PINS[i]) chk(out_rd_data, 5'h00, "output default");
    end
    chk(flag, 1'b0, "lock after reset");
    $display("test reset done");
  endtask
  // Codes 0 to 25, including gaps and two past the table, alternating inputs 0 and 19
  task automatic t_in_route;
    logic [4:0] k;
    for (int c = 0; c < 26; c++) begin
      k = c[0] ? 5'd19 : 5'd0;
      wr_in(k, c[5:0]);
      @(negedge clk);
      chk(p_in[k], exp_in(c[5:0]), "routed input");
    end
    $display("test input routing done");
  endtask
  task automatic t_buffers;
    logic [5:0] cs [4] = '{6'h13, 6'h14, 6'h12, 6'h02};
    for (int m = 0; m < 4; m++) begin
      i2c_mode = m[1];
      lvl = m[0] ? 24'hFF_FFFF : 24'h00_0000;
      for (int j = 0; j < 4; j++) begin
        wr_in(5'd13, cs[j]);
        @(negedge clk);
        chk(p_in[13], exp_in(cs[j]), "buffer choice");
        chk(pin_thr, m[1] ? 24'h18_0000 : 24'h00_0000, "thresholds");
      end
    end
    i2c_mode = 1'b0;
    $display("test buffers done");
  endtask
  task automatic t_out;
    logic [4:0] pn [5] = '{5'd0, 5'd12, 5'd19, 5'd23, 5'd6};
    logic [4:0] cd [5] = '{5'h10, 5'h01, 5'h16, 5'h00, 5'h03};
    logic [4:0] p, c;
    logic eo, ee;
    p_ovr = 32'h0041_0000;
    p_oe = 32'h0040_0000;
    // Data line of the serial engine shares one pin both ways
    wr_in(5'd14, 6'h13);
    for (int d = 0; d < 2; d++) begin
      dir = d ? 24'h55_5555 : 24'hAA_AAAA;
      for (int i = 0; i < 5; i++) begin
        p = pn[i];
        c = cd[i];
        wr_out(p, c);
        out_rd_idx = p;
        @(negedge clk);
        ee = (c != 5'h00 && p_ovr[c]) ? p_oe[c] : !dir[p];
        eo = (c == 5'h00) ? latch[p] : p_out[c];
        chk(pin_oe[p], ee & PINS[p], "pin enable");
        if (PINS[p]) begin
          chk(pin_out[p], eo, "pin data");
          chk(out_rd_data, c, "output select");
        end
      end
    end
    // Hand every driver back to the direction bits
    p_ovr = 32'h0000_0000;
    chk(p_in[14], exp_in(6'h13), "input kept");
    $display("test output routing done");
  endtask
  task automatic t_lock;
    wr_in(5'd0, 6'h04);
    wr_out(5'd0, 5'h02);
    lock_seq(8'h01);
    chk(flag, 1'b1, "lock set");
    wr_in(5'd0, 6'h17);
    wr_out(5'd0, 5'h07);
    in_rd_idx = 5'd0;
    out_rd_idx = 5'd0;
    @(negedge clk);
    chk(in_rd_data, 6'h04, "locked input");
    chk(out_rd_data, 5'h02, "locked output");
    chk(p_in[0], exp_in(6'h04), "frozen input");
    chk(pin_out[0], p_out[2], "frozen output");
    // Broken sequence must not clear the flag
    wr_lock(8'h55);
    wr_lock(8'h12);
    wr_lock(8'h00);
    chk(flag, 1'b1, "stray write");
    lock_seq(8'h00);
    chk(flag, 1'b0, "lock clear");
    wr_in(5'd0, 6'h17);
    @(negedge clk);
    chk(in_rd_data, 6'h17, "unlocked input");
    $display("test lock done");
  endtask
  task automatic t_fuse;
    fuse = 1'b1;
    power_on();
    lock_seq(8'h00);
    wr_in(5'd3, 6'h10);
    lock_seq(8'h01);
    chk(flag, 1'b1, "fuse set");
    lock_seq(8'h00);
    chk(flag, 1'b1, "fuse sticks");
    power_on();
    in_rd_idx = 5'd3;
    @(negedge clk);
    chk(flag, 1'b0, "lock dropped");
    chk(in_rd_data, IN_DEF[3], "default back");
    fuse = 1'b0;
    $display("test fuse done");
  endtask

  // ==========================================
  // Verdict, reached from the main sequence and the watchdog
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    t_reset();
    t_in_route();
    t_buffers();
    t_out();
    t_lock();
    t_fuse();
    results();
  end
  // Watchdog, well past the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    $display("BAD %0t watchdog expired", $time);
    results();
  end
endmodule
